// [dsp_mem_model.sv]
/*
  Behavioural sdram at the pins: keeps written words, returns them
  after the read latency. Assumes ddr3/ddr4 encodings for reads.
*/
`timescale 1ns/100ps
`include "dsp_regs.svh"
module dsp_mem_model (
  // command pins
  input  wire logic        ck,
  input  wire logic        cs_n,
  input  wire logic [2:0]  cmd_n,
  input  wire logic [22:0] ca,
  // data pins
  input  wire logic [71:0] dq_o,
  input  wire logic        dq_oe,
  input  wire logic [8:0]  dm,
  input  wire logic        dqs_o,
  output logic      [71:0] dq_i,
  output logic             dqs_i,
  // bench side
  input  wire logic [71:0] err_mask,
  output logic      [25:0] seen,
  output logic      [80:0] wr_seen
);
  logic [71:0] mem [16];
  logic [71:0] rd;
  // command taken at rising ck
  always @(posedge ck)
    if (!cs_n)
      seen <= {cmd_n, ca};
  // write word taken on the device strobe
  always @(posedge dqs_o)
    if (dq_oe) begin
      wr_seen <= {dm, dq_o};
      mem[seen[3:0]] <= dq_o;
    end
  // read: data, then strobe, then inverse when released
  initial begin
    dq_i = 72'h0;
    dqs_i = 1'b0;
    forever begin
      @(posedge ck);
      if (!cs_n && cmd_n == 3'h5) begin
        rd = mem[ca[3:0]] ^ err_mask;
        repeat (`DSP_RD_LAT) @(posedge ck);
        dq_i = rd;
        @(negedge ck);
        dqs_i = 1'b1;
        repeat (2) @(posedge ck);
        dq_i = ~rd;
        dqs_i = 1'b0;
      end
    end
  end
endmodule

// [dsp_monitor.sv]
/*
  Checker of the ddr pin block: ecc flags and sdram pins.
  Assumes binding into dsp_top, config static after reset.
*/
`timescale 1ns/100ps
module dsp_monitor
  import dsp_pkg::*;
(
  // clocks and reset
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        mem_clk,
  // user side
  input wire dsp_mem_e    mem_type,
  input wire logic        user_read_valid,
  input wire logic        single_error_flag,
  input wire logic        double_error_flag,
  input wire logic [6:0]  error_position,
  input wire logic        init_done,
  input wire logic        alert_error,
  // pins
  input wire logic        ck,
  input wire logic        ck_n,
  input wire logic        reset_n,
  input wire logic [15:0] addr,
  input wire logic [2:0]  ba,
  input wire logic [1:0]  bg,
  input wire logic        cs_n,
  input wire logic        cke,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic        par,
  input wire logic        dq_oe,
  input wire logic        dqs_oe,
  input wire logic        dqs_o,
  input wire logic        dqs_n_o
);
  logic        ddr4;
  logic [15:0] amask;
  logic [2:0]  bmask;
  assign ddr4 = (mem_type == DSP_DDR4);
  assign amask = ddr4 ? 16'h3FFF :
                 (mem_type == DSP_DDR3) ? 16'hFFFF : 16'h03FF;
  assign bmask = ddr4 ? 3'h3 : (mem_type == DSP_DDR3) ? 3'h7 : 3'h0;
  // ----------------------------------------------------------------
  // user side
  // ----------------------------------------------------------------
  flag_valid_a: assert property (@(posedge clk)
    disable iff (!resetn) (single_error_flag || double_error_flag)
    |-> user_read_valid && !(single_error_flag && double_error_flag))
    else $error("flag outside word");
  pos_void_a: assert property (@(posedge clk)
    disable iff (!resetn) user_read_valid && !single_error_flag
    |-> error_position == 7'h00) else $error("stale position");
  alert_a: assert property (@(posedge clk)
    disable iff (!resetn) !ddr4 |-> !alert_error)
    else $error("alert off ddr4");
  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  cke_init_a: assert property (@(posedge mem_clk)
    disable iff (!resetn) !init_done |-> !cke) else $error("early cke");
  ck_pair_a: assert property (@(posedge mem_clk)
    disable iff (!resetn) ck != ck_n) else $error("clock pair equal");
  addr_mask_a: assert property (@(posedge mem_clk)
    disable iff (!resetn) !cs_n |-> (addr & ~amask) == 16'h0000)
    else $error("address too wide");
  bank_mask_a: assert property (@(posedge mem_clk)
    disable iff (!resetn) !cs_n |-> (ba & ~bmask) == 3'h0
    && (ddr4 || bg == 2'h0)) else $error("bank bits wrong");
  par_calc_a: assert property (@(posedge mem_clk)
    disable iff (!resetn) !cs_n |-> par ==
    (ddr4 & ^{addr, ba, bg, ras_n, cas_n, we_n})) else $error("parity");
  lp_pins_a: assert property (@(posedge mem_clk)
    disable iff (!resetn) mem_type == DSP_LPDDR3 |-> {ras_n, cas_n,
    we_n} == 3'h7 && (!cke || reset_n)) else $error("lp pins driven");
  wr_strobe_a: assert property (@(posedge mem_clk)
    disable iff (!resetn) dq_oe |-> dqs_oe) else $error("no strobe");
  dqs_pair_a: assert property (@(posedge mem_clk)
    disable iff (!resetn) dqs_n_o == !dqs_o)
    else $error("strobe pair equal");
  cover property (@(posedge clk) single_error_flag);
  cover property (@(posedge clk) double_error_flag);
  cover property (@(posedge mem_clk) dq_oe);
endmodule

bind dsp_top dsp_monitor dsp_monitor_i (.clk, .resetn, .mem_clk,
  .mem_type, .user_read_valid, .single_error_flag, .double_error_flag,
  .error_position, .init_done, .alert_error, .ck, .ck_n, .reset_n,
  .addr, .ba, .bg, .cs_n, .cke, .ras_n, .cas_n, .we_n, .par, .dq_oe,
  .dqs_oe, .dqs_o, .dqs_n_o);

// [dsp_pkg.sv]
/*
  Types and ECC helpers of the DDR pin and ECC status block.
  Assumes dsp_regs.svh for shared constants.
*/
`include "dsp_regs.svh"
package dsp_pkg;

  typedef enum logic [1:0] {DSP_DDR3, DSP_DDR4, DSP_LPDDR3} dsp_mem_e;
  typedef enum logic [2:0] {DSP_ACT, DSP_PRE, DSP_RD, DSP_WR, DSP_MRS} dsp_cmd_e;
  typedef enum logic [1:0] {U_RESET, U_CKE, U_READY, U_BUSY} dsp_ust_e;
  typedef enum logic [2:0] {M_IDLE, M_CMD, M_WAIT, M_WDATA, M_RDATA,
                            M_DONE} dsp_mst_e;

  typedef struct packed {
    dsp_cmd_e    kind;
    logic [1:0]  bg;
    logic [2:0]  ba;
    logic [15:0] addr;
    logic [71:0] wdata;
    logic [8:0]  wmask;
  } dsp_cmd_s;

  typedef struct packed {
    logic [63:0] data;
    logic        single;
    logic        double;
    logic [6:0]  pos;
  } dsp_dec_s;

  // codeword position of data bit j, powers of two skipped
  function automatic logic [6:0] dsp_hpos(input int j);
    int p;
    int n;
    p = 0;
    n = -1;
    for (int k = 1; k < 72; k++) begin
      if (((k & (k - 1)) != 0) && (n < j)) begin
        n = n + 1;
        p = k;
      end
    end
    return p[6:0];
  endfunction

  function automatic logic [6:0] dsp_check(input logic [63:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int j = 0; j < 64; j++) begin
      if (d[j]) c = c ^ dsp_hpos(j);
    end
    return c;
  endfunction

  function automatic logic [71:0] dsp_encode(input logic [63:0] d);
    logic [6:0] c;
    c = dsp_check(d);
    return {^{c, d}, c, d};
  endfunction

  function automatic dsp_dec_s dsp_decode(input logic [71:0] cw);
    dsp_dec_s   r;
    logic [6:0] s;
    logic       ov;
    s = cw[70:64] ^ dsp_check(cw[63:0]);
    ov = ^cw;
    r.data = cw[63:0];
    r.single = ov;
    r.double = (s != 7'h00) && !ov;
    r.pos = `DSP_ERRPOS_CHECK;
    for (int j = 0; j < 64; j++) begin
      if (ov && (dsp_hpos(j) == s)) begin
        r.pos = 7'(j);
        r.data[j] = ~cw[j];
      end
    end
    return r;
  endfunction

endpackage

// [dsp_regs.svh]
/*
  Constants of the DDR pin and ECC status block: timing, widths, masks.
  Assumes inclusion by the block's package, top module and memory model only.
*/
`ifndef DSP_REGS_SVH
`define DSP_REGS_SVH

// ------------------------------------------------------------------
// clock and init timing
// ------------------------------------------------------------------
`define DSP_CLK_MHZ      100
`define DSP_T_RESET_US   200
`define DSP_T_CKE_US     500
`define DSP_RESET_CYC    (`DSP_T_RESET_US * `DSP_CLK_MHZ)
`define DSP_CKE_CYC      (`DSP_T_CKE_US * `DSP_CLK_MHZ)

// ------------------------------------------------------------------
// link latencies in forwarded clock cycles
// ------------------------------------------------------------------
`define DSP_WR_LAT       5
`define DSP_RD_LAT       5
`define DSP_RD_TMO       16

// ------------------------------------------------------------------
// pin masks per memory type
// ------------------------------------------------------------------
`define DSP_AMASK_LP     16'h03FF
`define DSP_AMASK_DDR3   16'hFFFF
`define DSP_AMASK_DDR4   16'h3FFF
`define DSP_BMASK_DDR3   3'h7
`define DSP_BMASK_DDR4   3'h3

// ------------------------------------------------------------------
// ecc layout
// ------------------------------------------------------------------
`define DSP_ECC_W        72
`define DSP_ERRPOS_CHECK 7'h40

`endif

// [dsp_top.sv]
/*
  DDR SDRAM pin interface with ECC read status, user side on clk,
  pin side on the link clock mem_clk. Assumes mem_clk is twice the
  wanted SDRAM clock rate and that config inputs are static after reset.
*/
`timescale 1ns/100ps
`include "dsp_regs.svh"
module dsp_top
  import dsp_pkg::*;
#(
  parameter int DQ_W      = 72,
  parameter int RESET_CYC = `DSP_RESET_CYC,
  parameter int CKE_CYC   = `DSP_CKE_CYC
)(
  // clocks and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              mem_clk,
  // configuration
  input  wire dsp_mem_e          mem_type,
  input  wire logic              odt_on_read,
  input  wire logic              odt_on_write,
  // user command
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire dsp_cmd_e          cmd_kind,
  input  wire logic [1:0]        cmd_bg,
  input  wire logic [2:0]        cmd_ba,
  input  wire logic [15:0]       cmd_addr,
  input  wire logic [((DQ_W==72)?64:DQ_W)-1:0] cmd_wdata,
  input  wire logic [((DQ_W==72)?8:(DQ_W+7)/8)-1:0] cmd_wmask,
  // user read and status
  output logic                   user_read_valid,
  output logic [((DQ_W==72)?64:DQ_W)-1:0] user_read_data,
  output logic                   single_error_flag,
  output logic                   double_error_flag,
  output logic [6:0]             error_position,
  output logic                   init_done,
  output logic                   alert_error,
  // sdram command pins
  output logic                   ck,
  output logic                   ck_n,
  output logic                   reset_n,
  output logic [15:0]            addr,
  output logic [2:0]             ba,
  output logic [1:0]             bg,
  output logic                   cs_n,
  output logic                   cke,
  output logic                   ras_n,
  output logic                   cas_n,
  output logic                   we_n,
  output logic                   odt,
  output logic                   par,
  input  wire logic              alert_n,
  // sdram data pins
  input  wire logic [DQ_W-1:0]   dq_i,
  output logic [DQ_W-1:0]        dq_o,
  output logic                   dq_oe,
  output logic [(DQ_W+7)/8-1:0]  dm,
  input  wire logic              dqs_i,
  output logic                   dqs_o,
  output logic                   dqs_n_o,
  output logic                   dqs_oe
);

  localparam bit ECC_ON = (DQ_W == 72);
  localparam int UW     = ECC_ON ? 64 : DQ_W;
  localparam int DMW    = (DQ_W + 7) / 8;

  // ------------------------------------------------------------------
  // state records
  // ------------------------------------------------------------------
  typedef struct packed {
    dsp_ust_e    st;
    logic [15:0] timer;
    logic        mrst;
    logic        cke_en;
    logic        ready;
    logic        req_tgl;
    dsp_cmd_s    cmd;
    logic [2:0]  ack_s;
    logic        rd_valid;
    logic [63:0] rd_data;
    logic        single;
    logic        double;
    logic [6:0]  pos;
    logic [1:0]  alert_s;
    logic        alert;
  } dsp_ustate_s;

  typedef struct packed {
    dsp_mst_e    st;
    logic        phase;
    logic [4:0]  cnt;
    logic [2:0]  req_s;
    logic        ack_tgl;
    dsp_cmd_s    cmd;
    logic [3:0]  type_s;
    logic [3:0]  odtcfg_s;
    logic [1:0]  mrst_s;
    logic [1:0]  cke_s;
    logic [71:0] dq_s0;
    logic [71:0] dq_s1;
    logic [2:0]  dqs_s;
    logic [71:0] rd_word;
    logic        ck;
    logic        ck_n;
    logic        reset_n;
    logic [15:0] addr;
    logic [2:0]  ba;
    logic [1:0]  bg;
    logic        cs_n;
    logic        cke;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        odt;
    logic        par;
    logic [71:0] dq_o;
    logic        dq_oe;
    logic [8:0]  dm;
    logic        dqs_o;
    logic        dqs_n_o;
    logic        dqs_oe;
  } dsp_mstate_s;

  dsp_ustate_s u_reg, u_next;
  dsp_mstate_s m_reg, m_next;
  logic [1:0]  rst_sync_reg;
  logic [1:0]  mrst_sync_reg;
  logic        rst_n;
  logic        mrst_n;

  // ------------------------------------------------------------------
  // reset release per domain
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rst_sync_reg <= 2'h0;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  always_ff @(posedge mem_clk or negedge resetn) begin
    if (!resetn) mrst_sync_reg <= 2'h0;
    else mrst_sync_reg <= {mrst_sync_reg[0], 1'b1};
  end

  assign rst_n  = rst_sync_reg[1];
  assign mrst_n = mrst_sync_reg[1];

  // ------------------------------------------------------------------
  // user domain: init timing, command hand-off, ecc decode
  // ------------------------------------------------------------------
  always_comb begin
    dsp_dec_s    dec;
    logic [71:0] cw;
    dec = dsp_decode(m_reg.rd_word);
    cw = 72'h0;
    u_next = u_reg;
    u_next.rd_valid = 1'b0;
    u_next.single = 1'b0;
    u_next.double = 1'b0;
    u_next.ack_s = {u_reg.ack_s[1], u_reg.ack_s[0], m_reg.ack_tgl};
    u_next.alert_s = {u_reg.alert_s[0], alert_n};
    u_next.alert = (mem_type == DSP_DDR4) && !u_reg.alert_s[1];
    case (u_reg.st)
      U_RESET: begin
        u_next.timer = u_reg.timer + 16'h0001;
        if (u_reg.timer == 16'(RESET_CYC - 1)) begin
          u_next.st = U_CKE;
          u_next.timer = 16'h0000;
          u_next.mrst = 1'b0;
        end
      end
      U_CKE: begin
        u_next.timer = u_reg.timer + 16'h0001;
        if (u_reg.timer == 16'(CKE_CYC - 1)) begin
          u_next.st = U_READY;
          u_next.cke_en = 1'b1;
          u_next.ready = 1'b1;
        end
      end
      U_READY: begin
        if (cmd_valid) begin
          if (ECC_ON) begin
            cw = dsp_encode(64'(cmd_wdata));
          end else begin
            cw = 72'(cmd_wdata);
          end
          u_next.cmd.kind = cmd_kind;
          u_next.cmd.bg = cmd_bg;
          u_next.cmd.ba = cmd_ba;
          u_next.cmd.addr = cmd_addr;
          u_next.cmd.wdata = cw;
          u_next.cmd.wmask = 9'(cmd_wmask);
          u_next.req_tgl = ~u_reg.req_tgl;
          u_next.ready = 1'b0;
          u_next.st = U_BUSY;
        end
      end
      U_BUSY: begin
        if (u_reg.ack_s[2] != u_reg.ack_s[1]) begin
          u_next.st = U_READY;
          u_next.ready = 1'b1;
          if (u_reg.cmd.kind == DSP_RD) begin
            u_next.rd_valid = 1'b1;
            if (ECC_ON) begin
              u_next.rd_data = dec.data;
              u_next.single = dec.single;
              u_next.double = dec.double;
              u_next.pos = dec.single ? dec.pos : 7'h00;
            end else begin
              u_next.rd_data = 64'(m_reg.rd_word);
              u_next.pos = 7'h00;
            end
          end
        end
      end
      default: u_next.st = U_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      u_reg <= '0;
      u_reg.st <= U_RESET;
      u_reg.mrst <= 1'b1;
      u_reg.alert_s <= 2'h3;
    end else begin
      u_reg <= u_next;
    end
  end

  // ------------------------------------------------------------------
  // link domain: pins, command issue, strobe capture
  // ------------------------------------------------------------------
  always_comb begin
    dsp_mem_e   mt;
    logic       ddr4;
    logic       lp;
    logic       step;
    logic [15:0] amask;
    logic [2:0] bmask;
    mt = dsp_mem_e'(m_reg.type_s[3:2]);
    ddr4 = (mt == DSP_DDR4);
    lp = (mt == DSP_LPDDR3);
    step = m_reg.phase;
    amask = lp ? `DSP_AMASK_LP : (ddr4 ? `DSP_AMASK_DDR4 : `DSP_AMASK_DDR3);
    bmask = lp ? 3'h0 : (ddr4 ? `DSP_BMASK_DDR4 : `DSP_BMASK_DDR3);
    m_next = m_reg;
    m_next.phase = ~m_reg.phase;
    m_next.ck = ~m_reg.phase;
    m_next.ck_n = m_reg.phase;
    m_next.req_s = {m_reg.req_s[1], m_reg.req_s[0], u_reg.req_tgl};
    m_next.type_s = {m_reg.type_s[1:0], mem_type};
    m_next.odtcfg_s = {m_reg.odtcfg_s[1:0], odt_on_read, odt_on_write};
    m_next.mrst_s = {m_reg.mrst_s[0], u_reg.mrst};
    m_next.cke_s = {m_reg.cke_s[0], u_reg.cke_en};
    m_next.dq_s0 = 72'(dq_i);
    m_next.dq_s1 = m_reg.dq_s0;
    m_next.dqs_s = {m_reg.dqs_s[1], m_reg.dqs_s[0], dqs_i};
    m_next.cke = m_reg.cke_s[1];
    m_next.reset_n = lp ? 1'b1 : ~m_reg.mrst_s[1];
    m_next.dqs_o = m_reg.dqs_oe & ~m_reg.phase;
    m_next.dqs_n_o = ~(m_reg.dqs_oe & ~m_reg.phase);
    case (m_reg.st)
      M_IDLE: begin
        if (step && (m_reg.req_s[1] != m_reg.ack_tgl)) begin
          m_next.cmd = u_reg.cmd;
          m_next.st = M_CMD;
          m_next.cs_n = 1'b0;
          m_next.addr = u_reg.cmd.addr & amask;
          m_next.ba = u_reg.cmd.ba & bmask;
          m_next.bg = ddr4 ? u_reg.cmd.bg : 2'h0;
          case (u_reg.cmd.kind)
            DSP_ACT: {m_next.ras_n, m_next.cas_n, m_next.we_n} = 3'h3;
            DSP_PRE: {m_next.ras_n, m_next.cas_n, m_next.we_n} = 3'h2;
            DSP_RD:  {m_next.ras_n, m_next.cas_n, m_next.we_n} = 3'h5;
            DSP_WR:  {m_next.ras_n, m_next.cas_n, m_next.we_n} = 3'h4;
            default: {m_next.ras_n, m_next.cas_n, m_next.we_n} = 3'h0;
          endcase
          if (lp) {m_next.ras_n, m_next.cas_n, m_next.we_n} = 3'h7;
          m_next.par = ddr4 & ^{m_next.addr, m_next.ba, m_next.bg,
                                m_next.ras_n, m_next.cas_n,
                                m_next.we_n};
        end
      end
      M_CMD: begin
        if (step) begin
          m_next.cs_n = 1'b1;
          {m_next.ras_n, m_next.cas_n, m_next.we_n} = 3'h7;
          m_next.par = 1'b0;
          m_next.cnt = 5'(`DSP_WR_LAT - 1);
          if (m_reg.cmd.kind == DSP_WR) begin
            m_next.st = M_WAIT;
            m_next.odt = m_reg.odtcfg_s[2];
          end else if (m_reg.cmd.kind == DSP_RD) begin
            m_next.st = M_WAIT;
            m_next.cnt = 5'(`DSP_RD_LAT - 1);
            m_next.odt = m_reg.odtcfg_s[3];
          end else begin
            m_next.st = M_DONE;
          end
        end
      end
      M_WAIT: begin
        if (step) begin
          m_next.cnt = m_reg.cnt - 5'h01;
          if (m_reg.cnt == 5'h00) begin
            if (m_reg.cmd.kind == DSP_WR) begin
              m_next.st = M_WDATA;
              m_next.dq_o = m_reg.cmd.wdata;
              m_next.dq_oe = 1'b1;
              m_next.dqs_oe = 1'b1;
              m_next.dm = ddr4 ? ~m_reg.cmd.wmask : m_reg.cmd.wmask;
            end else begin
              m_next.st = M_RDATA;
              m_next.cnt = 5'(`DSP_RD_TMO - 1);
            end
          end
        end
      end
      M_WDATA: begin
        if (step) begin
          m_next.dq_oe = 1'b0;
          m_next.dqs_oe = 1'b0;
          m_next.odt = 1'b0;
          m_next.dm = 9'h000;
          m_next.st = M_DONE;
        end
      end
      M_RDATA: begin
        if (m_reg.dqs_s[1] && !m_reg.dqs_s[2]) begin
          m_next.rd_word = m_reg.dq_s1;
          m_next.odt = 1'b0;
          m_next.st = M_DONE;
        end else if (step) begin
          m_next.cnt = m_reg.cnt - 5'h01;
          if (m_reg.cnt == 5'h00) begin
            m_next.rd_word = m_reg.dq_s1;
            m_next.odt = 1'b0;
            m_next.st = M_DONE;
          end
        end
      end
      M_DONE: begin
        m_next.ack_tgl = ~m_reg.ack_tgl;
        m_next.st = M_IDLE;
      end
      default: m_next.st = M_IDLE;
    endcase
  end

  always_ff @(posedge mem_clk or negedge mrst_n) begin
    if (!mrst_n) begin
      m_reg <= '0;
      m_reg.st <= M_IDLE;
      m_reg.ck_n <= 1'b1;
      m_reg.cs_n <= 1'b1;
      m_reg.ras_n <= 1'b1;
      m_reg.cas_n <= 1'b1;
      m_reg.we_n <= 1'b1;
      m_reg.dqs_n_o <= 1'b1;
      m_reg.mrst_s <= 2'h3;
    end else begin
      m_reg <= m_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign cmd_ready         = u_reg.ready;
  assign user_read_valid   = u_reg.rd_valid;
  assign user_read_data    = u_reg.rd_data[UW-1:0];
  assign single_error_flag = u_reg.single;
  assign double_error_flag = u_reg.double;
  assign error_position    = u_reg.pos;
  assign init_done         = u_reg.cke_en;
  assign alert_error       = u_reg.alert;
  assign ck                = m_reg.ck;
  assign ck_n              = m_reg.ck_n;
  assign reset_n           = m_reg.reset_n;
  assign addr              = m_reg.addr;
  assign ba                = m_reg.ba;
  assign bg                = m_reg.bg;
  assign cs_n              = m_reg.cs_n;
  assign cke               = m_reg.cke;
  assign ras_n             = m_reg.ras_n;
  assign cas_n             = m_reg.cas_n;
  assign we_n              = m_reg.we_n;
  assign odt               = m_reg.odt;
  assign par               = m_reg.par;
  assign dq_o              = m_reg.dq_o[DQ_W-1:0];
  assign dq_oe             = m_reg.dq_oe;
  assign dm                = m_reg.dm[DMW-1:0];
  assign dqs_o             = m_reg.dqs_o;
  assign dqs_n_o           = m_reg.dqs_n_o;
  assign dqs_oe            = m_reg.dqs_oe;

endmodule

// [tb_top.sv]
/*
  Bench of dsp_top with the behavioural sdram, all memory types.
  Assumes short init counts and the model's read latency.
*/
`timescale 1ns/100ps
module tb_top
  import dsp_pkg::*;
;
  logic        clk = 1'b0, mem_clk = 1'b0, resetn = 1'b0;
  dsp_mem_e    mem_type = DSP_DDR3;
  dsp_cmd_e    cmd_kind = DSP_ACT;
  logic        odt_on_read = 1'b0, odt_on_write = 1'b0;
  logic        cmd_valid = 1'b0, alert_n = 1'b1;
  logic [1:0]  cmd_bg = 2'h0, bg;
  logic [2:0]  cmd_ba = 3'h0, ba;
  logic [15:0] cmd_addr = 16'h0000, addr;
  logic [63:0] cmd_wdata = 64'h0123456789ABCDEF, user_read_data;
  logic [7:0]  cmd_wmask = 8'h0F;
  logic [71:0] dq_i, dq_o, err_mask = 72'h0;
  logic [8:0]  dm;
  logic [6:0]  error_position;
  logic [25:0] seen;
  logic [80:0] wr_seen;
  logic [72:0] rsp;
  logic        cmd_ready, user_read_valid, single_error_flag, init_done;
  logic        double_error_flag, alert_error, ck, ck_n, reset_n, cs_n;
  logic        cke, ras_n, cas_n, we_n, odt, par, dq_oe, dqs_i, dqs_o;
  logic        dqs_n_o, dqs_oe, odt_hi = 1'b0;
  logic [2:0]  enc [5] = '{3'h3, 3'h2, 3'h5, 3'h4, 3'h0};
  logic [15:0] amask [3] = '{16'hFFFF, 16'h3FFF, 16'h03FF};
  logic [2:0]  bmask [3] = '{3'h7, 3'h3, 3'h0};
  int          miscompares = 0, total_checks = 0;

  always #5 clk = ~clk;
  initial begin
    #3.7;
    forever #80 mem_clk = ~mem_clk;
  end

  dsp_top #(.DQ_W(72), .RESET_CYC(128), .CKE_CYC(8)) dsp_top_i (.clk,
    .resetn, .mem_clk, .mem_type, .odt_on_read, .odt_on_write,
    .cmd_valid, .cmd_ready, .cmd_kind, .cmd_bg, .cmd_ba, .cmd_addr,
    .cmd_wdata, .cmd_wmask, .user_read_valid, .user_read_data,
    .single_error_flag, .double_error_flag, .error_position,
    .init_done, .alert_error, .ck, .ck_n, .reset_n, .addr, .ba, .bg,
    .cs_n, .cke, .ras_n, .cas_n, .we_n, .odt, .par, .alert_n, .dq_i,
    .dq_o, .dq_oe, .dm, .dqs_i, .dqs_o, .dqs_n_o, .dqs_oe);

  dsp_mem_model dsp_mem_model_i (.ck, .cs_n,
    .cmd_n({ras_n, cas_n, we_n}), .ca({odt, par, bg, ba, addr}),
    .dq_o, .dq_oe, .dm, .dqs_o, .dq_i, .dqs_i, .err_mask, .seen,
    .wr_seen);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks=%0d bad=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [72:0] e, input logic [72:0] g);
    total_checks++;
    if (e !== g) begin
      miscompares++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1) begin
      tick();
      n++;
      if (user_read_valid === 1'b1)
        rsp = {single_error_flag, double_error_flag, error_position,
               user_read_data};
      if (odt === 1'b1)
        odt_hi = 1'b1;
      if (n > 2000) begin
        miscompares++;
        final_report();
      end
    end
  endtask

  task automatic issue(input dsp_cmd_e k, input logic [2:0] b,
                       input logic [1:0] g, input logic [15:0] a);
    logic [2:0]  c;
    logic [15:0] ea;
    logic [2:0]  eb;
    logic [1:0]  eg;
    logic        eo;
    logic        ep;
    wait_ready();
    rsp = 'x;
    odt_hi = 1'b0;
    cmd_kind = k;
    cmd_ba = b;
    cmd_bg = g;
    cmd_addr = a;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    wait_ready();
    c = (mem_type == DSP_LPDDR3) ? 3'h7 : enc[k];
    ea = a & amask[mem_type];
    eb = b & bmask[mem_type];
    eg = (mem_type == DSP_DDR4) ? g : 2'h0;
    eo = (k == DSP_RD) ? odt_on_read : (k == DSP_WR) && odt_on_write;
    ep = (mem_type == DSP_DDR4) && (^{ea, eb, eg, c});
    chk({c, eo, ep, eg, eb, ea},
        {seen[25:23], odt_hi, seen[21:0]});
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    for (int t = 0; t < 3; t++) begin
      mem_type = dsp_mem_e'(t);
      odt_on_read = t[0];
      odt_on_write = !t[0];
      resetn = 1'b0;
      repeat (50) tick();
      resetn = 1'b1;
      repeat (100) tick();
      chk(mem_type == DSP_LPDDR3, reset_n);
      issue(DSP_MRS, 3'h7, 2'h3, 16'hFFFF);
      chk(1'b1, reset_n);
      issue(DSP_ACT, 3'h5, 2'h2, 16'hA5C3);
      issue(DSP_PRE, 3'h2, 2'h1, 16'h0400);
      issue(DSP_WR, 3'h1, 2'h1, 16'h0003);
      chk({(mem_type == DSP_DDR4) ? 9'h1F0 : 9'h00F, cmd_wdata},
          {wr_seen[80:72], wr_seen[63:0]});
      for (int e = 0; e < 3 && mem_type != DSP_LPDDR3; e++) begin
        err_mask = (e == 0) ? 72'h0 : (e == 1) ? 72'h20 : 72'h220;
        issue(DSP_RD, 3'h1, 2'h1, 16'h0003);
        chk({e == 1, e == 2, (e == 1) ? 7'h05 : 7'h00,
             (e == 2) ? 64'h0 : cmd_wdata},
            {rsp[72:64], (e == 2) ? 64'h0 : rsp[63:0]});
        chk(e == 2, rsp[71]);
      end
      err_mask = 72'h0;
      alert_n = 1'b0;
      repeat (6) tick();
      chk(mem_type == DSP_DDR4, alert_error);
      alert_n = 1'b1;
      $display("test of memory type %0d done", t);
    end
    final_report();
  end
endmodule
